// ==== logic/bit_sync.sv ====
// Two-stage synchroniser for asynchronous level inputs.
`timescale 1ns/100ps
`default_nettype none
module bit_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule : bit_sync
`default_nettype wire

// ==== logic/reset_source_and_vector_logic.sv ====
// Reset source combination, release delay timer, reset cause flags and vector table.
//
// Overview of operation
// [R1] Low reset pin resets asynchronously, clock stopped.
// [R2] Pin release starts delay timer, then release.
// [R3] Brown-out detector acts only with fuse programmed.
// [R4] Enabled brown-out asserts reset immediately.
// [R5] Brown-out release waits the power-on delay.
// [R6] Level fuse picks 1.8V or 2.7V threshold.
// [R7] Watchdog pulse one cycle; its end starts timer.
// [R8] Basic cause register bits 7..2 read zero.
// [R9] Basic pin flag set by pin reset.
// [R10] Basic power-on flag set only by power-on.
// [R11] Basic flags decode watchdog, pin or power-on.
// [R12] Extended cause register bits 7..4 read zero.
// [R13] Watchdog flag set; power-on or zero-write clears.
// [R14] Brown-out flag set; power-on or zero-write clears.
// [R15] Pin flag set; power-on or zero-write clears.
// [R16] Power-on flag cleared only by zero write.
// [R17] Software reads then clears flags early.
// [R18] Four or five interrupt sources, own vectors.
// [R19] Interrupt needs own enable and global enable.
// [R20] Lowest vector address has highest priority.
// [R21] Vector map from reset at zero upward.
// [R22] Clock select fuses default to code 0010.
// [R23] Real-time delay counts watchdog oscillator cycles.
// [R24] Wake from sleep uses clock count only.
// [R25] Release only when all sources idle, timer done.
`timescale 1ns/100ps
`default_nettype none
module reset_source_and_vector_logic
  import rsv_pkg::*;
#(
  parameter bit EXTENDED = 1'b1,
  parameter int unsigned WDT_DIV = 25,
  parameter int unsigned CK_16K = 16384,
  parameter int unsigned CK_32K = 32768
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic ext_reset_n_in,
  input wire logic brownout_low_in,
  input wire logic wdt_timeout_in,
  input wire logic wake_in,
  input wire rsv_pkg::fuse_cfg_t fuse_in,
  input wire logic [rsv_pkg::IRQ_N-1:0] irq_req_in,
  input wire logic [rsv_pkg::REG_AW-1:0] reg_addr_in,
  input wire logic [rsv_pkg::REG_DW-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [rsv_pkg::REG_DW-1:0] reg_rdata_out,
  output logic cpu_rst_out,
  output logic core_stall_out,
  output logic bod_level_high_out,
  output rsv_pkg::vector_t vector_out
);
  import rsv_pkg::*;

  localparam int unsigned NSRC = EXTENDED ? IRQ_N : IRQ_N - 1;
  localparam logic [3:0] RCS_MASK = EXTENDED ? RCS_EXT_MASK : RCS_BASIC_MASK;
  localparam int unsigned DIV_W = $clog2(WDT_DIV + 1);

  if (WDT_DIV < 1 || CK_16K < 1 || CK_16K > 65536 ||
      CK_32K < 1 || CK_32K > 65536) begin : g_bad_param
    $error("divider or cycle count parameter out of range");
  end

  // Pin, enabled brown-out and power-on reset the sequencer without needing a clock edge.
  // The release is not synchronised, so the first state after release is the hold state.
  logic bod_en;
  logic core_arst;
  assign bod_en = (fuse_in.brownout_enable == FUSE_PROG); // [R3]
  assign core_arst = sys_rst_in | ~ext_reset_n_in | (bod_en & brownout_low_in); // [R1] [R4]

  logic pin_n_s;
  logic bod_low_s;
  bit_sync #(.W(1), .RST_VAL(1'b1)) pin_sync (
    .clk_in(mclk_in),
    .rst_in(sys_rst_in),
    .async_in(ext_reset_n_in),
    .sync_out(pin_n_s)
  );
  bit_sync #(.W(1), .RST_VAL(1'b0)) bod_sync (
    .clk_in(mclk_in),
    .rst_in(sys_rst_in),
    .async_in(brownout_low_in),
    .sync_out(bod_low_s)
  );

  logic pin_low_s;
  logic bod_act_s;
  logic src_active;
  assign pin_low_s = ~pin_n_s;
  assign bod_act_s = bod_en & bod_low_s; // [R3]
  assign src_active = pin_low_s | bod_act_s | wdt_timeout_in; // [R25]

  // Fuses are followed live while the core is held, so even the first release after power-on
  // uses the fitted values; they freeze once a delay starts, so a change never alters it.
  fuse_cfg_t fuse_reg;
  fuse_cfg_t fuse_next;
  seq_state_t state_reg;
  seq_state_t state_next;

  always_comb begin
    fuse_next = fuse_reg;
    if (state_reg == ST_HOLD) begin
      fuse_next = fuse_in;
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      fuse_reg <= '{clock_select: CLKSEL_DEFAULT, brownout_enable: 1'b1, brownout_level: 1'b1}; // [R22]
    end else begin
      fuse_reg <= fuse_next;
    end
  end

  function automatic delay_sel_t delay_decode(input logic [3:0] sel);
    delay_sel_t d;
    d.rt = RT_NONE;
    d.ck = CKS_FEW;
    case (sel)
      4'hf: d = '{rt: RT_NONE, ck: CKS_1K};
      4'he: d = '{rt: RT_SHORT, ck: CKS_1K};
      4'hd: d = '{rt: RT_LONG, ck: CKS_1K};
      4'hc: d = '{rt: RT_NONE, ck: CKS_16K};
      4'hb: d = '{rt: RT_SHORT, ck: CKS_16K};
      4'ha: d = '{rt: RT_LONG, ck: CKS_16K};
      4'h9: d = '{rt: RT_LONG, ck: CKS_1K};
      4'h8: d = '{rt: RT_LONG, ck: CKS_32K};
      4'h6, 4'h3, 4'h0: d = '{rt: RT_SHORT, ck: CKS_FEW};
      4'h5, 4'h2: d = '{rt: RT_LONG, ck: CKS_FEW};
      default: d = '{rt: RT_NONE, ck: CKS_FEW};
    endcase
    return d;
  endfunction : delay_decode

  delay_sel_t dsel;
  logic [CNT_W-1:0] tick_len;
  logic [CNT_W-1:0] ck_len;
  logic level_prog;

  always_comb begin
    dsel = delay_decode(fuse_next.clock_select); // [R22]
    level_prog = (fuse_next.brownout_level == FUSE_PROG);
    case (dsel.rt)
      RT_SHORT: tick_len = level_prog ? TICKS_SHORT_HIGH : TICKS_SHORT_LOW; // [R23]
      RT_LONG: tick_len = level_prog ? TICKS_LONG_HIGH : TICKS_LONG_LOW; // [R23]
      default: tick_len = '0;
    endcase
    case (dsel.ck)
      CKS_1K: ck_len = CK_1K;
      CKS_16K: ck_len = CNT_W'(CK_16K);
      CKS_32K: ck_len = CNT_W'(CK_32K);
      default: ck_len = CK_FEW;
    endcase
  end

  // Divider standing in for the watchdog oscillator: one enable pulse per WDT_DIV clocks.
  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  logic tick_en;

  always_comb begin
    tick_en = (div_reg == DIV_W'(WDT_DIV - 1));
    div_next = tick_en ? '0 : div_reg + 1'b1;
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  // Release sequencer.
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic wake_reg;
  logic wake_next;
  logic cpu_rst_reg;
  logic cpu_rst_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    wake_next = wake_reg;
    if (src_active) begin
      state_next = ST_HOLD; // [R25] [R7]
      wake_next = 1'b0;
    end else begin
      case (state_reg)
        ST_HOLD: begin
          if (tick_len != '0) begin
            state_next = ST_TICKS; // [R2] [R5]
            cnt_next = tick_len - 1'b1;
          end else begin
            state_next = ST_CYCLES;
            cnt_next = ck_len - 1'b1;
          end
        end
        ST_TICKS: begin
          if (tick_en) begin
            if (cnt_reg == '0) begin
              state_next = ST_CYCLES;
              cnt_next = ck_len - 1'b1;
            end else begin
              cnt_next = cnt_reg - 1'b1; // [R23]
            end
          end
        end
        ST_CYCLES: begin
          if (cnt_reg == '0) begin
            state_next = ST_RUN; // [R2]
            wake_next = 1'b0;
          end else begin
            cnt_next = cnt_reg - 1'b1;
          end
        end
        ST_RUN: begin
          if (wake_in) begin
            state_next = ST_CYCLES; // [R24]
            cnt_next = ck_len - 1'b1;
            wake_next = 1'b1;
          end
        end
        default: state_next = ST_HOLD;
      endcase
    end
    cpu_rst_next = !(state_next == ST_RUN || wake_next); // [R25]
  end

  always_ff @(posedge mclk_in or posedge core_arst) begin
    if (core_arst) begin
      state_reg <= ST_HOLD;
      cnt_reg <= '0;
      wake_reg <= 1'b0;
      cpu_rst_reg <= 1'b1; // [R1] [R4]
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      wake_reg <= wake_next;
      cpu_rst_reg <= cpu_rst_next;
    end
  end

  // Reset cause flags survive every reset except power-on.
  logic [RCS_W-1:0] rcs_reg;
  logic [RCS_W-1:0] rcs_next;
  logic [RCS_W-1:0] rcs_set;
  logic wr_rcs;
  assign wr_rcs = reg_wr_in && (reg_addr_in == RCS_OFF);

  always_comb begin
    rcs_set = '0;
    rcs_set[EXT_BIT] = pin_low_s; // [R9] [R15]
    rcs_set[BOR_BIT] = bod_act_s; // [R14]
    rcs_set[WDT_BIT] = wdt_timeout_in; // [R13]
    rcs_next = rcs_reg;
    if (wr_rcs) begin
      rcs_next = rcs_reg & reg_wdata_in[RCS_W-1:0]; // [R13] [R14] [R15] [R16]
    end
    // A source that fires in the clearing cycle still leaves its flag set.
    rcs_next = (rcs_next | rcs_set) & RCS_MASK; // [R8] [R10] [R11] [R12]
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rcs_reg <= RCS_RESET; // [R10] [R16]
    end else begin
      rcs_reg <= rcs_next;
    end
  end

  // Interrupt enables; cleared by power-on, pin and enabled brown-out reset, but not by a watchdog reset.
  logic [REG_DW-1:0] irq_en_reg;
  logic [REG_DW-1:0] irq_en_next;

  always_comb begin
    irq_en_next = irq_en_reg;
    if (reg_wr_in && reg_addr_in == IRQ_EN_OFF) begin
      irq_en_next = reg_wdata_in & IRQ_EN_MASK;
    end
  end

  always_ff @(posedge mclk_in or posedge core_arst) begin
    if (core_arst) begin
      irq_en_reg <= IRQ_EN_RESET;
    end else begin
      irq_en_reg <= irq_en_next;
    end
  end

  // Register read port: data stand only in the cycle after the strobe.
  logic [REG_DW-1:0] rdata_reg;
  logic [REG_DW-1:0] rdata_next;
  logic bod_hi_reg;
  logic bod_hi_next;

  always_comb begin
    rdata_next = '0;
    if (reg_rd_in) begin
      case (reg_addr_in)
        RCS_OFF: rdata_next = {{(REG_DW - RCS_W){1'b0}}, rcs_reg}; // [R8] [R12] [R17]
        IRQ_EN_OFF: rdata_next = irq_en_reg;
        default: rdata_next = '0;
      endcase
    end
    bod_hi_next = (fuse_reg.brownout_level == FUSE_PROG); // [R6]
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_reg <= '0;
      bod_hi_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      bod_hi_reg <= bod_hi_next;
    end
  end

  vector_arbiter #(.N(NSRC)) arbiter (
    .clk_in(mclk_in),
    .rst_in(core_arst),
    .hold_in(cpu_rst_reg),
    .req_in(irq_req_in[NSRC-1:0]), // [R18]
    .en_in(irq_en_reg[NSRC-1:0]),
    .gie_in(irq_en_reg[GIE_BIT]),
    .vector_out(vector_out)
  );

  assign reg_rdata_out = rdata_reg;
  assign cpu_rst_out = cpu_rst_reg;
  assign core_stall_out = wake_reg;
  assign bod_level_high_out = bod_hi_reg;

  src_hold_a: assert property (@(posedge mclk_in) disable iff (core_arst) // [R25]
    src_active |=> cpu_rst_out && state_reg == ST_HOLD)
    else $error("reset released while a source was active");

  timer_release_a: assert property (@(posedge mclk_in) disable iff (core_arst) // [R2]
    (state_reg == ST_CYCLES && cnt_reg == '0 && !src_active) |=> (state_reg == ST_RUN && !cpu_rst_out))
    else $error("processor not released when delay expired");

  wdt_pulse_start_a: assert property (@(posedge mclk_in) disable iff (core_arst) // [R7]
    (wdt_timeout_in && !pin_low_s && !bod_act_s) ##1 !src_active |=> state_reg != ST_HOLD)
    else $error("delay timer not started after watchdog pulse");

  wake_short_a: assert property (@(posedge mclk_in) disable iff (core_arst) // [R24]
    (state_reg == ST_RUN && wake_in && !src_active) |=> (core_stall_out && !cpu_rst_out && state_reg == ST_CYCLES && cnt_reg == ck_len - 1'b1))
    else $error("wake did not use the clock-count delay only");

  pin_flag_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [R9] [R15]
    pin_low_s |=> rcs_reg[EXT_BIT])
    else $error("pin reset flag not set");

  wdt_flag_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [R13]
    wdt_timeout_in |=> rcs_reg[WDT_BIT] == EXTENDED)
    else $error("watchdog flag wrong after watchdog reset");

  bod_gate_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [R3]
    (!bod_en && !rcs_reg[BOR_BIT] && !(wr_rcs && reg_wdata_in[BOR_BIT])) |=> !rcs_reg[BOR_BIT])
    else $error("brown-out flag set with detector disabled");

  zero_write_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [R16]
    (wr_rcs && !reg_wdata_in[POR_BIT]) |=> !rcs_reg[POR_BIT])
    else $error("power-on flag not cleared by zero write");

  rsvd_zero_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in) // [R8] [R12]
    $past(reg_rd_in) |-> (reg_rdata_out[REG_DW-1:RCS_W] == '0 || !$past(reg_addr_in == RCS_OFF)) && (EXTENDED || reg_rdata_out[3:2] == 2'b00 || !$past(reg_addr_in == RCS_OFF)))
    else $error("reserved cause bits read non-zero");
endmodule : reset_source_and_vector_logic
`default_nettype wire

// ==== logic/rsv_pkg.sv ====
// Shared constants, types and register map of the reset source and vector logic.
package rsv_pkg;
  localparam int unsigned REG_AW = 8;
  localparam int unsigned REG_DW = 8;
  localparam int unsigned RCS_W = 4;
  localparam int unsigned IRQ_N = 5;
  localparam int unsigned VEC_W = 9;
  localparam int unsigned CNT_W = 16;

  // Register offsets.
  localparam logic [7:0] RCS_OFF = 8'h00;
  localparam logic [7:0] IRQ_EN_OFF = 8'h01;

  // Reset cause field positions and values.
  localparam int unsigned POR_BIT = 0;
  localparam int unsigned EXT_BIT = 1;
  localparam int unsigned BOR_BIT = 2;
  localparam int unsigned WDT_BIT = 3;
  localparam logic [3:0] RCS_RESET = 4'h1;
  localparam logic [3:0] RCS_BASIC_MASK = 4'h3;
  localparam logic [3:0] RCS_EXT_MASK = 4'hf;

  // Interrupt enable register: bit 7 is the global enable, bits 4..0 the sources.
  localparam int unsigned GIE_BIT = 7;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;
  localparam logic [7:0] IRQ_EN_MASK = 8'h9f;

  // Fuses read 0 when programmed.
  localparam logic FUSE_PROG = 1'b0;
  localparam logic [3:0] CLKSEL_DEFAULT = 4'h2;

  // Watchdog oscillator cycle counts of the real-time delay part.
  localparam logic [15:0] TICKS_SHORT_LOW = 16'h0100;
  localparam logic [15:0] TICKS_SHORT_HIGH = 16'h0400;
  localparam logic [15:0] TICKS_LONG_LOW = 16'h1000;
  localparam logic [15:0] TICKS_LONG_HIGH = 16'h4000;

  // System clock counts of the clock-counting delay part.
  localparam logic [15:0] CK_FEW = 16'h0006;
  localparam logic [15:0] CK_1K = 16'h0400;

  localparam logic [8:0] RESET_VECTOR = 9'h000;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_TICKS = 2'b01,
    ST_CYCLES = 2'b10,
    ST_RUN = 2'b11
  } seq_state_t;

  typedef enum logic [1:0] {
    RT_NONE = 2'b00,
    RT_SHORT = 2'b01,
    RT_LONG = 2'b10
  } realtime_sel_t;

  typedef enum logic [1:0] {
    CKS_FEW = 2'b00,
    CKS_1K = 2'b01,
    CKS_16K = 2'b10,
    CKS_32K = 2'b11
  } ck_sel_t;

  typedef struct packed {
    realtime_sel_t rt;
    ck_sel_t ck;
  } delay_sel_t;

  typedef struct packed {
    logic [3:0] clock_select;
    logic brownout_enable;
    logic brownout_level;
  } fuse_cfg_t;

  typedef struct packed {
    logic valid;
    logic [8:0] addr;
  } vector_t;
endpackage : rsv_pkg

// ==== logic/vector_arbiter.sv ====
// Fixed-priority interrupt vector selection; lower vector address wins.
`timescale 1ns/100ps
`default_nettype none
module vector_arbiter
  import rsv_pkg::*;
#(
  parameter int unsigned N = 5
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic hold_in,
  input wire logic [N-1:0] req_in,
  input wire logic [N-1:0] en_in,
  input wire logic gie_in,
  output rsv_pkg::vector_t vector_out
);
  vector_t vec_reg;
  vector_t vec_next;
  logic [N-1:0] take;

  always_comb begin
    take = req_in & en_in & {N{gie_in}}; // [R19]
    vec_next.valid = 1'b0;
    vec_next.addr = RESET_VECTOR;
    if (hold_in) begin
      vec_next.valid = 1'b1; // [R20]
    end else begin
      for (int i = N - 1; i >= 0; i--) begin
        if (take[i]) begin
          vec_next.valid = 1'b1;
          vec_next.addr = VEC_W'(i + 1); // [R20] [R21]
        end
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      vec_reg <= '{valid: 1'b1, addr: RESET_VECTOR};
    end else begin
      vec_reg <= vec_next;
    end
  end

  assign vector_out = vec_reg;

  top_prio_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R20]
    (!hold_in && req_in[0] && en_in[0] && gie_in) |=> (vector_out.addr == 9'h001))
    else $error("highest interrupt did not win");
endmodule : vector_arbiter
`default_nettype wire

// ==== verification/board_model.sv ====
// Board side model: reset pin circuitry, supply monitor and watchdog that drive the block.
`timescale 1ns/100ps
`default_nettype none
module board_model (
  input wire logic clk_in,
  output logic pin_reset_n_out,
  output logic supply_low_out,
  output logic wdt_pulse_out
);
  // The pin has a pull-up on the board, so a released pin reads high.
  initial begin
    pin_reset_n_out = 1'b1;
    supply_low_out = 1'b0;
    wdt_pulse_out = 1'b0;
  end

  // A low pin is held for whole clocks, far longer than the shortest pulse that must count.
  task automatic pin_drive(input logic level);
    @(posedge clk_in);
    pin_reset_n_out <= level;
  endtask : pin_drive

  task automatic supply_drive(input logic low);
    @(posedge clk_in);
    supply_low_out <= low;
  endtask : supply_drive

  // Exactly one clock wide; a longer pulse would only hold the reset longer, as the delay starts at its end.
  task automatic wdt_fire();
    @(posedge clk_in);
    wdt_pulse_out <= 1'b1;
    @(posedge clk_in);
    wdt_pulse_out <= 1'b0;
  endtask : wdt_fire
endmodule : board_model
`default_nettype wire

// ==== verification/test_reset_source_and_vector_logic.sv ====
// Testbench of the reset source and vector logic, extended and basic variants side by side.
`timescale 1ns/100ps
`default_nettype none
module test_reset_source_and_vector_logic;
  import rsv_pkg::*;
  localparam int CKN = 6;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic wake_in = 1'b0;
  fuse_cfg_t fuse_in = {4'h7, 1'b1, 1'b1};
  logic [IRQ_N-1:0] irq_req_in = 5'h00;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic ext_reset_n, brownout_low, wdt_timeout;
  logic [7:0] reg_rdata_out, rdata_basic;
  logic cpu_rst_out, core_stall_out, bod_level_high_out;
  logic basic_rst, basic_stall, basic_bod_hi;
  vector_t basic_vector;
  vector_t vector_out;
  int n_mismatch = 0;
  int comparisons = 0;
  int rst_cycles = 0;

  always #20 mclk_in = ~mclk_in;
  always @(negedge mclk_in) if (cpu_rst_out === 1'b1) rst_cycles++;

  board_model u_board (.clk_in(mclk_in), .pin_reset_n_out(ext_reset_n),
    .supply_low_out(brownout_low), .wdt_pulse_out(wdt_timeout));

  reset_source_and_vector_logic #(.WDT_DIV(1)) u_dut (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ext_reset_n_in(ext_reset_n),
    .brownout_low_in(brownout_low), .wdt_timeout_in(wdt_timeout), .wake_in(wake_in),
    .fuse_in(fuse_in), .irq_req_in(irq_req_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .cpu_rst_out(cpu_rst_out), .core_stall_out(core_stall_out),
    .bod_level_high_out(bod_level_high_out), .vector_out(vector_out));

  reset_source_and_vector_logic #(.EXTENDED(1'b0), .WDT_DIV(1)) u_basic (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ext_reset_n_in(ext_reset_n),
    .brownout_low_in(brownout_low), .wdt_timeout_in(wdt_timeout), .wake_in(wake_in),
    .fuse_in(fuse_in), .irq_req_in(irq_req_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(rdata_basic), .cpu_rst_out(basic_rst), .core_stall_out(basic_stall),
    .bod_level_high_out(basic_bod_hi), .vector_out(basic_vector));

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_cnt(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask : cmp_cnt

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe, so they are taken mid-cycle there.
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d, output logic [7:0] db);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    @(negedge mclk_in);
    d = reg_rdata_out;
    db = rdata_basic;
  endtask : reg_read

  // The basic variant keeps only the pin and power-on flags.
  task automatic check_cause(input logic [7:0] exp);
    logic [7:0] d, db;
    reg_read(RCS_OFF, d, db);
    cmp_val({8'h00, d}, {8'h00, exp});
    cmp_val({8'h00, db}, {8'h00, exp & {4'h0, RCS_BASIC_MASK}});
  endtask : check_cause

  task automatic wait_release();
    int n;
    n = 0;
    do begin
      @(negedge mclk_in);
      n++;
    end while (cpu_rst_out !== 1'b0 && n < 3000);
    cmp_cnt(n, 1, 2999);
  endtask : wait_release

  task automatic pin_reset_cycle();
    u_board.pin_drive(1'b0);
    #2;
    cmp_val({15'h0, cpu_rst_out}, 16'h0001);
    cmp_val({15'h0, basic_rst}, 16'h0001);
    repeat (4) @(posedge mclk_in);
    u_board.pin_drive(1'b1);
    wait_release();
  endtask : pin_reset_cycle

  initial begin
    int b;
    logic [7:0] d, db;
    repeat (8) @(posedge mclk_in);
    @(negedge mclk_in);
    cmp_val({6'h0, vector_out}, {6'h0, 1'b1, RESET_VECTOR});
    @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    wait_release();
    cmp_cnt(rst_cycles, 8 + CKN, 8 + CKN + 6);
    check_cause(8'h01);
    $display("test power_on done");

    b = rst_cycles;
    pin_reset_cycle();
    cmp_cnt(rst_cycles - b, CKN + 4, CKN + 12);
    check_cause(8'h03);
    reg_write(RCS_OFF, 8'hfd);
    check_cause(8'h01);
    reg_write(RCS_OFF, 8'hff);
    check_cause(8'h01);
    reg_write(RCS_OFF, 8'h00);
    check_cause(8'h00);
    pin_reset_cycle();
    check_cause(8'h02);
    reg_write(RCS_OFF, 8'h00);
    $display("test pin_reset done");

    b = rst_cycles;
    u_board.wdt_fire();
    wait_release();
    cmp_cnt(rst_cycles - b, CKN, CKN + 6);
    check_cause(8'h08);
    reg_write(RCS_OFF, 8'h00);
    $display("test watchdog done");

    b = rst_cycles;
    u_board.supply_drive(1'b1);
    repeat (10) @(posedge mclk_in);
    u_board.supply_drive(1'b0);
    repeat (4) @(negedge mclk_in);
    cmp_cnt(rst_cycles - b, 0, 0);
    check_cause(8'h00);
    @(posedge mclk_in);
    fuse_in <= {4'h7, FUSE_PROG, FUSE_PROG};
    pin_reset_cycle();
    cmp_val({15'h0, bod_level_high_out}, 16'h0001);
    cmp_val({15'h0, basic_bod_hi}, 16'h0001);
    reg_write(RCS_OFF, 8'h00);
    u_board.supply_drive(1'b1);
    #2;
    cmp_val({15'h0, cpu_rst_out}, 16'h0001);
    repeat (3) @(posedge mclk_in);
    b = rst_cycles;
    u_board.supply_drive(1'b0);
    wait_release();
    cmp_cnt(rst_cycles - b, CKN, CKN + 8);
    check_cause(8'h04);
    reg_write(RCS_OFF, 8'h00);
    $display("test brownout done");

    for (int lv = 1; lv >= 0; lv--) begin
      @(posedge mclk_in);
      fuse_in <= {4'h6, 1'b1, 1'(lv)};
      b = rst_cycles;
      pin_reset_cycle();
      cmp_cnt(rst_cycles - b, (lv ? 256 : 1024) + CKN + 4, (lv ? 256 : 1024) + CKN + 14);
    end
    $display("test start_up_delay done");

    b = rst_cycles;
    @(posedge mclk_in);
    wake_in <= 1'b1;
    @(posedge mclk_in);
    wake_in <= 1'b0;
    for (int s = 0; s < 100; s++) begin
      @(negedge mclk_in);
      if (core_stall_out !== 1'b1) begin
        cmp_cnt(s, CKN - 1, CKN + 2);
        cmp_val({15'h0, basic_stall}, 16'h0000);
        break;
      end
    end
    cmp_cnt(rst_cycles - b, 0, 0);
    $display("test wake done");

    reg_write(IRQ_EN_OFF, 8'hff);
    reg_read(IRQ_EN_OFF, d, db);
    cmp_val({8'h00, d}, {8'h00, IRQ_EN_MASK});
    reg_read(8'h05, d, db);
    cmp_val({8'h00, d}, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk_in);
      irq_req_in <= 5'h1f << i;
      @(posedge mclk_in);
      @(negedge mclk_in);
      cmp_val({6'h0, vector_out}, {6'h0, 1'b1, 9'(i + 1)});
      cmp_val({6'h0, basic_vector}, {6'h0, 1'(i < 4), (i < 4) ? 9'(i + 1) : 9'h000});
    end
    reg_write(IRQ_EN_OFF, 8'h1f);
    repeat (2) @(negedge mclk_in);
    cmp_val({15'h0, vector_out.valid}, 16'h0000);
    reg_write(IRQ_EN_OFF, 8'h80);
    repeat (2) @(negedge mclk_in);
    cmp_val({15'h0, vector_out.valid}, 16'h0000);
    $display("test vectors done");
    close_out();
  end

  initial begin
    #2000000;
    n_mismatch++;
    close_out();
  end
endmodule : test_reset_source_and_vector_logic
`default_nettype wire
